// ---- verilog/odi_map.vh ----
// Constants of the eight-channel digital input readout.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef ODI_MAP_VH
`define ODI_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ODI_CLK_MHZ 200
`define ODI_UPDATE_US 6500
`define ODI_MS_US 1000

// ----------------------------------------
// Function codes
// ----------------------------------------
`define ODI_FC_BITS 8'h02
`define ODI_FC_HOLD 8'h03
`define ODI_FC_INREG 8'h04

// ----------------------------------------
// Area bases: flat then legacy five digit
// ----------------------------------------
`define ODI_FLAT_ALLOC_BIT 16'h0000
`define ODI_LEG_ALLOC_BIT 16'h2711
`define ODI_FLAT_ALLOC_WORD 16'h0400
`define ODI_LEG_ALLOC_WORD 16'hB3B1
`define ODI_FLAT_SLOT_BIT 16'h0400
`define ODI_LEG_SLOT_BIT 16'h32C9
`define ODI_FLAT_MSTAT_BIT 16'h0800
`define ODI_LEG_MSTAT_BIT 16'h36B1
`define ODI_FLAT_MSTAT_WORD 16'h0300
`define ODI_LEG_MSTAT_WORD 16'h8980
`define ODI_FLAT_TYPE_WORD 16'h0400
`define ODI_LEG_TYPE_WORD 16'h89E4

// ----------------------------------------
// Error strategies
// ----------------------------------------
`define ODI_ERR_CURRENT 2'h0
`define ODI_ERR_SUBST 2'h1
`define ODI_ERR_LAST 2'h2

// ----------------------------------------
// Module status byte fields
// ----------------------------------------
`define ODI_MS_FAULT 0
`define ODI_MS_SIM 1
`define ODI_MS_OVR 2

`endif

// ---- verilog/odi_chan.v ----
// One input channel: OFF delay, negation, fault strategy, simulation.
// Assumes a one-cycle ms_tick every millisecond and synchronous inputs.
`timescale 1ns/1ps
`include "odi_map.vh"

module odi_chan #(
  parameter DLY_W = 8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire ms_tick,
  input wire raw,
  input wire open_det,
  input wire short_det,
  input wire lfd_en,
  input wire negate,
  input wire sim_mode,
  input wire sim_val,
  input wire sim_invalid,
  input wire [1:0] err_mode,
  input wire subst_val,
  input wire [DLY_W-1:0] off_delay_ms,
  output reg state_q,
  output reg fault_q
);
  reg [DLY_W-1:0] hold_cnt_q;
  reg last_valid_q;
  wire fault;
  wire stretched;
  wire logical;
  reg state_d;
  reg fault_d;

  // ----------------------------------------
  // Detection and conditioning
  // ----------------------------------------
  assign fault = lfd_en & (open_det | short_det);
  // Falling edge held while the countdown runs
  assign stretched = raw | (hold_cnt_q != {DLY_W{1'b0}});
  assign logical = stretched ^ negate;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt_q <= {DLY_W{1'b0}};
      last_valid_q <= 1'b0;
    end else begin
      if (raw) begin
        hold_cnt_q <= off_delay_ms;
      end else if (ms_tick && hold_cnt_q != {DLY_W{1'b0}}) begin
        hold_cnt_q <= hold_cnt_q - {{(DLY_W-1){1'b0}}, 1'b1};
      end
      if (!fault) begin
        last_valid_q <= logical;
      end
    end
  end

  always @* begin
    state_d = logical;
    fault_d = fault;
    if (sim_mode) begin
      state_d = sim_val;
      fault_d = sim_invalid;
    end else if (fault) begin
      case (err_mode)
        `ODI_ERR_SUBST: state_d = subst_val;
        `ODI_ERR_LAST: state_d = last_valid_q;
        default: state_d = logical;
      endcase
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fault_q <= fault_d;
    end
  end
endmodule

// ---- verilog/odi_fifo.v ----
// Small FIFO with a registered output stage.
// Assumes one clock; valid and ready handshakes on both sides.
`timescale 1ns/1ps

module odi_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid_q,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // Capacity is DEPTH plus the output stage
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  assign pop = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_q] <= in_data;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q <= mem[rptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ---- verilog/odi_readout.v ----
// Eight-channel digital input readout: conditioning, periodic packing,
// buffered hand-off to the communication unit and master read service.
// Assumes synchronous field inputs and one 200 MHz clock.
`timescale 1ns/1ps
`include "odi_map.vh"

module odi_readout #(
  parameter NCH = 8,
  parameter DLY_W = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter MS_CYC = `ODI_MS_US * `ODI_CLK_MHZ,
  parameter UPDATE_CYC = `ODI_UPDATE_US * `ODI_CLK_MHZ,
  parameter [15:0] TYPE_CODE = 16'h0A5C
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [NCH-1:0] chan_raw,
  input wire [NCH-1:0] chan_open,
  input wire [NCH-1:0] chan_short,
  input wire [NCH-1:0] lfd_en,
  input wire [NCH-1:0] negate,
  input wire [NCH-1:0] sim_mode,
  input wire [NCH-1:0] sim_val,
  input wire [NCH-1:0] sim_invalid,
  input wire [2*NCH-1:0] err_mode,
  input wire [NCH-1:0] subst_val,
  input wire [DLY_W*NCH-1:0] off_delay_ms,
  input wire ovr_clr,
  output reg ovr_q,
  output wire cu_valid,
  input wire cu_ready,
  output wire [15:0] cu_data,
  input wire [7:0] slot,
  input wire [15:0] alloc_bit,
  input wire [15:0] alloc_word,
  input wire rd_req,
  input wire [7:0] rd_fc,
  input wire [15:0] rd_addr,
  input wire rd_legacy,
  output reg rd_ack_q,
  output reg rd_err_q,
  output reg [15:0] rd_data_q
);
  // TYPE_CODE default is arbitrary.
  // Integer-wide dividers: tick compares need no truncation
  localparam CW = 32;

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  reg [CW-1:0] ms_cnt_q;
  reg [CW-1:0] upd_cnt_q;
  wire ms_tick;
  wire upd_tick;

  // Millisecond tick paces every channel's OFF delay
  assign ms_tick = (ms_cnt_q == MS_CYC - 1);
  assign upd_tick = (upd_cnt_q == UPDATE_CYC - 1);

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ms_cnt_q <= {CW{1'b0}};
      upd_cnt_q <= {CW{1'b0}};
    end else begin
      ms_cnt_q <= ms_tick ? {CW{1'b0}} : ms_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      // Free-running period, independent of how often the master polls
      upd_cnt_q <= upd_tick ? {CW{1'b0}} :
        upd_cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  wire [NCH-1:0] ch_state;
  wire [NCH-1:0] ch_fault;
  wire [2*NCH-1:0] pack_w;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // Inputs sampled every cycle, far faster than a 50 Hz toggle
      odi_chan #(.DLY_W(DLY_W)) u_ch (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ms_tick(ms_tick),
        .raw(chan_raw[g]),
        .open_det(chan_open[g]),
        .short_det(chan_short[g]),
        .lfd_en(lfd_en[g]),
        .negate(negate[g]),
        .sim_mode(sim_mode[g]),
        .sim_val(sim_val[g]),
        .sim_invalid(sim_invalid[g]),
        .err_mode(err_mode[2*g+1:2*g]),
        .subst_val(subst_val[g]),
        .off_delay_ms(off_delay_ms[DLY_W*g+DLY_W-1:DLY_W*g]),
        .state_q(ch_state[g]),
        .fault_q(ch_fault[g])
      );
      // Channel g owns bits 2g and 2g+1 of the word
      assign pack_w[2*g] = ch_state[g];
      assign pack_w[2*g+1] = ch_fault[g];
    end
  endgenerate

  // ----------------------------------------
  // Snapshot and push
  // ----------------------------------------
  reg [15:0] snap_q;
  reg pend_q;
  wire fifo_in_ready;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      snap_q <= 16'h0000;
      pend_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (upd_tick) begin
        // One capture of all sixteen bits together
        snap_q <= pack_w[15:0];
        pend_q <= 1'b1;
      end else if (fifo_in_ready) begin
        pend_q <= 1'b0;
      end
      // A stuck consumer loses the older sample; set beats clear
      if (upd_tick && pend_q && !fifo_in_ready) begin
        ovr_q <= 1'b1;
      end else if (ovr_clr) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Input byte 1 in the low half, input byte 2 in the high half
  odi_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(pend_q),
    .in_ready(fifo_in_ready),
    .in_data(snap_q),
    .out_valid_q(cu_valid),
    .out_ready(cu_ready),
    .out_data_q(cu_data)
  );

  // ----------------------------------------
  // Published image, as delivered to the unit
  // ----------------------------------------
  reg [15:0] img_q;
  reg [7:0] mstat;
  wire [NCH-1:0] img_flt;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      img_q <= 16'h0000;
    end else if (cu_valid && cu_ready) begin
      img_q <= cu_data;
    end
  end

  // Fault flags of the delivered image, one per channel
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_flt
      assign img_flt[g] = img_q[2*g+1];
    end
  endgenerate

  // Fault bit follows the delivered image, not the live inputs
  always @* begin
    mstat = 8'h00;
    mstat[`ODI_MS_FAULT] = |img_flt;
    mstat[`ODI_MS_SIM] = |sim_mode;
    mstat[`ODI_MS_OVR] = ovr_q;
  end

  // ----------------------------------------
  // Master read service
  // ----------------------------------------
  reg [15:0] b_abit;
  reg [15:0] b_aword;
  reg [15:0] b_sbit;
  reg [15:0] b_mbit;
  reg [15:0] b_mword;
  reg [15:0] b_tword;
  reg [15:0] idx;
  reg [15:0] n;
  reg [15:0] slot8;
  reg [15:0] data_d;
  reg err_d;

  // ----------------------------------------
  // Area bases of the selected scheme
  // ----------------------------------------
  always @* begin
    b_abit = rd_legacy ? `ODI_LEG_ALLOC_BIT : `ODI_FLAT_ALLOC_BIT;
    b_aword = rd_legacy ? `ODI_LEG_ALLOC_WORD : `ODI_FLAT_ALLOC_WORD;
    b_sbit = rd_legacy ? `ODI_LEG_SLOT_BIT : `ODI_FLAT_SLOT_BIT;
    b_mbit = rd_legacy ? `ODI_LEG_MSTAT_BIT : `ODI_FLAT_MSTAT_BIT;
    b_mword = rd_legacy ? `ODI_LEG_MSTAT_WORD : `ODI_FLAT_MSTAT_WORD;
    b_tword = rd_legacy ? `ODI_LEG_TYPE_WORD : `ODI_FLAT_TYPE_WORD;
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Areas tried from the highest base down; in the flat scheme the slot
  // area shadows allocated bit addresses from 1024 upward
  always @* begin
    slot8 = {5'h00, slot, 3'h0};
    idx = 16'h0000;
    n = 16'h0000;
    data_d = 16'h0000;
    err_d = 1'b1;
    case (rd_fc)
      `ODI_FC_BITS: begin
        if (rd_addr >= b_mbit) begin
          idx = rd_addr - b_mbit;
          n = idx + 16'h0001 - slot8;
          if (idx + 16'h0001 >= slot8 && n < 16'h0008) begin
            data_d = {15'h0000, mstat[n[2:0]]};
            err_d = 1'b0;
          end
        end else if (rd_addr >= b_sbit) begin
          idx = rd_addr - b_sbit;
          n = idx + 16'h0001 - slot8;
          // Byte two follows byte one at the next slot's eight bits
          if (idx + 16'h0001 >= slot8 && n < 16'h0010) begin
            data_d = {15'h0000, img_q[n[3:0]]};
            err_d = 1'b0;
          end
        end else if (rd_addr >= b_abit) begin
          idx = rd_addr - b_abit;
          n = idx - alloc_bit;
          if (idx >= alloc_bit && n < 16'h0010) begin
            data_d = {15'h0000, img_q[n[3:0]]};
            err_d = 1'b0;
          end
        end
      end
      // One word per module in the allocated word area
      `ODI_FC_HOLD: begin
        if (rd_addr >= b_aword && rd_addr - b_aword == alloc_word) begin
          data_d = img_q;
          err_d = 1'b0;
        end
      end
      // Both words sit at base plus slot; the base gap keeps them apart
      `ODI_FC_INREG: begin
        if (rd_addr >= b_mword && rd_addr - b_mword == {8'h00, slot}) begin
          data_d = {8'h00, mstat};
          err_d = 1'b0;
        end else if (rd_addr >= b_tword &&
                     rd_addr - b_tword == {8'h00, slot}) begin
          data_d = TYPE_CODE;
          err_d = 1'b0;
        end
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Answer register
  // ----------------------------------------
  // Data and error stand until the next request replaces them
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ack_q <= 1'b0;
      rd_err_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_ack_q <= rd_req;
      if (rd_req) begin
        rd_err_q <= err_d;
        rd_data_q <= data_d;
      end
    end
  end
endmodule

// ---- tb/odi_asserts.sv ----
// Port checker for the readout: stream hand-off and read answers.
// Assumes binding into odi_readout; watches its ports only.
`timescale 1ns/1ps
module odi_asserts #(
  parameter [15:0] TYPE_CODE = 16'h0A5C
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire ovr_clr,
  input wire ovr_q,
  input wire cu_valid,
  input wire cu_ready,
  input wire [15:0] cu_data,
  input wire [7:0] slot,
  input wire rd_req,
  input wire [7:0] rd_fc,
  input wire [15:0] rd_addr,
  input wire rd_legacy,
  input wire rd_ack_q,
  input wire rd_err_q,
  input wire [15:0] rd_data_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ----
  // Read port
  // ----
  AST_ACK: assert property (rd_req |=> rd_ack_q)
    else $error("read not acknowledged");
  AST_NO_ACK: assert property (!rd_req |=> !rd_ack_q)
    else $error("acknowledge without request");
  AST_RD_HOLD: assert property (!rd_req |=>
    $stable(rd_data_q) && $stable(rd_err_q))
    else $error("read answer changed without request");
  AST_BAD_FC: assert property (rd_req && (rd_fc < 8'h02 ||
    rd_fc > 8'h04) |=> rd_err_q && rd_data_q == 16'h0000)
    else $error("unserved code not refused");
  AST_TYPE: assert property (rd_req && rd_fc == 8'h04 &&
    !rd_legacy && rd_addr == 16'h0400 + {8'h00, slot}
    |=> rd_data_q == TYPE_CODE && !rd_err_q)
    else $error("type word wrong");
  AST_STAT: assert property (rd_req && rd_fc == 8'h04 &&
    rd_legacy && rd_addr == 16'h8980 + {8'h00, slot}
    |=> rd_data_q[15:3] == 13'h0000 && !rd_err_q)
    else $error("status word wrong");
  // ----
  // Stream port
  // ----
  AST_HOLD: assert property (cu_valid && !cu_ready |=>
    cu_valid && $stable(cu_data))
    else $error("stream word dropped or changed");
  AST_FRESH: assert property (cu_valid && cu_ready
    |-> ##[1:70] cu_valid)
    else $error("no fresh word within one update period");
  AST_OVR: assert property (ovr_q && !ovr_clr |=> ovr_q)
    else $error("overrun flag lost");
endmodule
bind odi_readout odi_asserts #(.TYPE_CODE(TYPE_CODE)) i_odi_asserts (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .ovr_clr(ovr_clr),
  .ovr_q(ovr_q), .cu_valid(cu_valid), .cu_ready(cu_ready),
  .cu_data(cu_data), .slot(slot), .rd_req(rd_req), .rd_fc(rd_fc),
  .rd_addr(rd_addr), .rd_legacy(rd_legacy), .rd_ack_q(rd_ack_q),
  .rd_err_q(rd_err_q), .rd_data_q(rd_data_q));

// ---- tb/odi_cu_model.sv ----
// Communication unit model draining the readout's input words.
// Assumes the readout's clock; slow gives random stalls, hold stops it.
`timescale 1ns/1ps
module odi_cu_model (
  input wire clk_sys,
  input wire sys_rst,
  input wire slow,
  input wire hold,
  input wire cu_valid,
  input wire [15:0] cu_data,
  output reg cu_ready,
  output reg got_q,
  output reg [15:0] word_q
);
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cu_ready <= 1'b0;
      got_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      // Whole word taken at once, both bytes together
      got_q <= cu_valid && cu_ready;
      if (cu_valid && cu_ready) begin
        word_q <= cu_data;
      end
      cu_ready <= !hold && (!slow || $urandom_range(1) == 1);
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the eight-channel readout.
// Assumes short tick parameters so a run stays a few thousand cycles.
`timescale 1ns/1ps
module tb;
  localparam DLY = 1;
  localparam [15:0] TYPE = 16'h1234; // Arbitrary type code
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] chan_raw, chan_open, chan_short, lfd_en, negate, sim_mode;
  reg [7:0] sim_val, sim_invalid, subst_val, lastv, prevok, slot, rd_fc;
  reg [15:0] err_mode, alloc_bit, alloc_word, rd_addr, img, sb, b;
  reg [63:0] off_delay_ms;
  reg ovr_clr, rd_req, rd_legacy, slow, hold, f;
  wire ovr_q, cu_valid, cu_ready, rd_ack_q, rd_err_q, got_q;
  wire [15:0] cu_data, rd_data_q, word_q;
  integer failures = 0;
  integer checks = 0;
  integer i, n, lg;
  always #2.5 clk_sys = ~clk_sys;
  odi_readout #(.MS_CYC(10), .UPDATE_CYC(65), .TYPE_CODE(TYPE))
    i_odi_readout (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .chan_raw(chan_raw), .chan_open(chan_open), .chan_short(chan_short),
    .lfd_en(lfd_en), .negate(negate), .sim_mode(sim_mode),
    .sim_val(sim_val), .sim_invalid(sim_invalid), .err_mode(err_mode),
    .subst_val(subst_val), .off_delay_ms(off_delay_ms),
    .ovr_clr(ovr_clr), .ovr_q(ovr_q), .cu_valid(cu_valid),
    .cu_ready(cu_ready), .cu_data(cu_data), .slot(slot),
    .alloc_bit(alloc_bit), .alloc_word(alloc_word), .rd_req(rd_req),
    .rd_fc(rd_fc), .rd_addr(rd_addr), .rd_legacy(rd_legacy),
    .rd_ack_q(rd_ack_q), .rd_err_q(rd_err_q), .rd_data_q(rd_data_q));
  odi_cu_model i_odi_cu_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .slow(slow), .hold(hold), .cu_valid(cu_valid), .cu_data(cu_data),
    .cu_ready(cu_ready), .got_q(got_q), .word_q(word_q));
  // ----
  // Checking helpers
  // ----
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task print_verdict;
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic [15:0] exp_word(input [7:0] lv);
    reg s, e;
    integer g;
    begin
      for (g = 0; g < 8; g = g + 1) begin
        e = lfd_en[g] & (chan_open[g] | chan_short[g]);
        s = chan_raw[g] ^ negate[g];
        if (sim_mode[g]) begin
          s = sim_val[g];
          e = sim_invalid[g];
        end else if (e && err_mode[2*g+:2] == 2'h1) begin
          s = subst_val[g];
        end else if (e && err_mode[2*g+:2] == 2'h2) begin
          s = lv[g];
        end
        exp_word[2*g] = s;
        exp_word[2*g+1] = e;
      end
    end
  endfunction
  // Bounded wait for the model to take a word
  task wait_pop;
    integer k;
    k = 0;
    @(posedge clk_sys);
    #DLY;
    while (got_q !== 1'b1 && k < 400) begin
      @(posedge clk_sys);
      #DLY;
      k = k + 1;
    end
    chk("stream pop", {15'h0000, got_q}, 16'h0001);
  endtask
  task rd(input [7:0] fc, input [15:0] a, input [15:0] ed, input ee);
    @(posedge clk_sys);
    #DLY;
    rd_req = 1'b1;
    rd_fc = fc;
    rd_addr = a;
    rd_legacy = lg[0];
    @(posedge clk_sys);
    #DLY;
    rd_req = 1'b0;
    chk("read ack", {15'h0000, rd_ack_q}, 16'h0001);
    chk("read data", rd_data_q, ed);
    chk("read error", {15'h0000, rd_err_q}, {15'h0000, ee});
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    print_verdict;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {chan_raw, chan_open, chan_short, lfd_en, negate, sim_mode} = 48'h0;
    {sim_val, sim_invalid, subst_val, lastv, prevok, rd_fc} = 48'h0;
    {err_mode, off_delay_ms, ovr_clr, rd_req, rd_legacy, hold} = 84'h0;
    slow = 1'b0;
    rd_addr = 16'h0000;
    lg = 0;
    n = $urandom(27);
    // Two-slot module: slot+1 is left empty for it
    slot = 8'h01 + $urandom_range(58);
    alloc_bit = $urandom_range(511);
    alloc_word = $urandom_range(511);
    sb = {8'h00, slot};
    repeat (20) @(posedge clk_sys);
    #DLY;
    sys_rst = 1'b0;
    for (i = 0; i < 24; i = i + 1) begin
      {chan_raw, chan_open, chan_short, lfd_en, negate} = {$urandom, $urandom};
      {sim_val, sim_invalid, subst_val, err_mode} = {$urandom, $urandom};
      sim_mode = $urandom & $urandom;
      slow = $urandom;
      // Last valid strategy only after a fault-free, unsimulated pass
      for (n = 0; n < 8; n = n + 1) begin
        if (err_mode[2*n+:2] == 2'h2 && !prevok[n]) begin
          err_mode[2*n+:2] = 2'h0;
        end
      end
      repeat (3) wait_pop;
      chk("stream word", word_q, exp_word(lastv));
      for (n = 0; n < 8; n = n + 1) begin
        f = lfd_en[n] & (chan_open[n] | chan_short[n]);
        prevok[n] = !sim_mode[n] && !f;
        if (prevok[n]) begin
          lastv[n] = chan_raw[n] ^ negate[n];
        end
      end
    end
    // Falling edge held back by ten millisecond ticks
    // Driven like an active input, so detection stays off
    {chan_open, lfd_en, negate, sim_mode, slow} = 33'h0;
    chan_raw = 8'h01;
    off_delay_ms = 64'h0A;
    repeat (3) wait_pop;
    chan_raw = 8'h00;
    wait_pop;
    chk("held state", word_q, 16'h0001);
    repeat (3) wait_pop;
    chk("released state", word_q, 16'h0000);
    // Open line on channel 8 so the image carries a fault flag
    lfd_en = 8'h80;
    chan_open = 8'h80;
    repeat (2) wait_pop;
    chk("line fault", {15'h0000, word_q[15]}, 16'h0001);
    // Stalled consumer: queue fills, then snapshots overwrite
    hold = 1'b1;
    repeat (1300) @(posedge clk_sys);
    #DLY;
    chk("overrun", {15'h0000, ovr_q}, 16'h0001);
    img = word_q;
    for (lg = 0; lg < 2; lg = lg + 1) begin
      b = lg ? 16'h32C9 : 16'h0400;
      for (n = 0; n < 16; n = n + 1) begin
        rd(8'h02, b + 8 * sb + n - 1, {15'h0000, img[n]}, 1'b0);
        b = lg ? 16'h2711 : 16'h0000;
        rd(8'h02, b + alloc_bit + n, {15'h0000, img[n]}, 1'b0);
        b = lg ? 16'h32C9 : 16'h0400;
      end
      b = lg ? 16'h36B1 : 16'h0800;
      f = |(img & 16'hAAAA);
      rd(8'h02, b + 8 * sb - 1, {15'h0000, f}, 1'b0);
      rd(8'h02, b + 8 * sb + 2 - 1, 16'h0001, 1'b0);
      rd(8'h02, b + 8 * sb + 7 - 1, 16'h0000, 1'b0);
      b = lg ? 16'hB3B1 : 16'h0400;
      rd(8'h03, b + alloc_word, img, 1'b0);
      rd(8'h03, b + alloc_word + 1, 16'h0000, 1'b1);
      b = lg ? 16'h8980 : 16'h0300;
      rd(8'h04, b + sb, {13'h0000, 1'b1, 1'b0, f}, 1'b0);
      b = lg ? 16'h89E4 : 16'h0400;
      rd(8'h04, b + sb, TYPE, 1'b0);
      rd(8'h01, b + sb, 16'h0000, 1'b1);
    end
    // Drain with the consumer running again
    hold = 1'b0;
    n = 0;
    repeat (100) begin
      @(posedge clk_sys);
      #DLY;
      n = n + got_q;
    end
    chk("drained words", {15'h0000, n >= 17}, 16'h0001);
    ovr_clr = 1'b1;
    @(posedge clk_sys);
    #DLY;
    ovr_clr = 1'b0;
    chk("overrun cleared", {15'h0000, ovr_q}, 16'h0000);
    print_verdict;
  end
endmodule
